// ---- pmt_cfg_ram.sv ----
// Purpose: Working memory for configuration words, indexed by command
// Assumes: Contents are not reset; only the read register is
// Notes:   Nonvolatile copy lives outside and is reached by pulses
`timescale 1ns/1ps
module pmt_cfg_ram #(
	parameter int AW = 8,
	parameter int DW = 16
) (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	pmt_ram_if.mem    ram
);
	logic [DW-1:0] mem [2**AW];

	always_ff @(posedge clk_i) begin
		if (ram.we) begin
			mem[ram.waddr] <= ram.wdata;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ram.rdata <= '0;
		end else begin
			ram.rdata <= mem[ram.raddr];
		end
	end
endmodule

// ---- pmt_host_model.sv ----
// Purpose: Behavioural bus host that drives the management port
// Assumes: Open-drain lines with pull-ups; the bench resolves the wire
// Notes:   The clock line stands high between frames
`timescale 1ns/1ps
module pmt_host_model (
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_oe_n_o
);
	// Half period in ns; 100 gives the bench rate, 5000 gives 100 kHz
	int         half = 100;
	// Short idle gap: bursts here stay far below 30 ms
	int         gap = 2000;
	logic [7:0] pec;

	initial begin
		scl_o = 1'b1;
		sda_oe_n_o = 1'b1;
		pec = 8'h00;
	end

	// Bit-serial check byte, independent of any table
	function automatic logic [7:0] crc_step(input logic [7:0] c,
	                                        input logic [7:0] d);
		logic [7:0] r;
		logic       fb;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			fb = r[7] ^ d[i];
			r = {r[6:0], 1'b0} ^ (fb ? 8'h07 : 8'h00);
		end
		return r;
	endfunction

	// Data moves only while the clock is low
	task automatic put_bit(input logic b);
		#(half / 2) sda_oe_n_o = b;
		#(half / 2) scl_o = 1'b1;
		#(half) scl_o = 1'b0;
	endtask

	task automatic get_bit(output logic b);
		#(half / 2) sda_oe_n_o = 1'b1;
		#(half / 2) scl_o = 1'b1;
		#(half / 2) b = sda_i;
		#(half / 2) scl_o = 1'b0;
	endtask

	task automatic start(input logic rep);
		if (rep) begin
			#(half / 2) sda_oe_n_o = 1'b1;
			#(half / 2) scl_o = 1'b1;
			#(half / 2);
		end else begin
			pec = 8'h00;
		end
		sda_oe_n_o = 1'b0;
		#(half / 2) scl_o = 1'b0;
	endtask

	task automatic stop();
		#(half / 2) sda_oe_n_o = 1'b0;
		#(half / 2) scl_o = 1'b1;
		#(half / 2) sda_oe_n_o = 1'b1;
		#(gap);
	endtask

	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) put_bit(b[i]);
		get_bit(a);
		pec = crc_step(pec, b);
		ack = ~a;
	endtask

	task automatic get_byte(input logic last, output logic [7:0] b);
		for (int i = 7; i >= 0; i--) get_bit(b[i]);
		put_bit(last);
		pec = crc_step(pec, b);
	endtask
endmodule

// ---- pmt_pkg.sv ----
// Purpose: Shared constants, types and helpers for the management port
// Assumes: 40 MHz core clock, bus clock sampled as an ordinary input
// Notes:   Command codes limited to the subset the port decodes
package pmt_pkg;

	localparam int CLK_HZ        = 40_000_000;
	localparam int STD_BUS_HZ    = 100_000;
	localparam int FAST_BUS_HZ   = 400_000;
	// Core cycles per bus clock period at the fast rate
	localparam int FAST_BUS_CYC  = CLK_HZ / FAST_BUS_HZ;

	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [6:0] ADDR_BASE     = 7'h60;
	localparam int         ADDR_BANDS    = 14;
	localparam logic [6:0] ADDR_FALLBACK = 7'h7e;
	localparam logic [6:0] ADDR_FACTORY  = 7'h7f;
	localparam logic [1:0] SEL_SETTLE    = 2'h3;

	localparam logic [7:0] CRC_POLY      = 8'h07;
	localparam logic [7:0] CRC_INIT      = 8'h00;
	localparam logic [7:0] IDLE_BYTE     = 8'hff;
	localparam int         STAT_CML_BIT  = 1;

	localparam logic [7:0] CMD_OPERATION   = 8'h01;
	localparam logic [7:0] CMD_ON_OFF_CFG  = 8'h02;
	localparam logic [7:0] CMD_CLEAR_FLT   = 8'h03;
	localparam logic [7:0] CMD_WRITE_PROT  = 8'h10;
	localparam logic [7:0] CMD_STORE_ALL   = 8'h11;
	localparam logic [7:0] CMD_RESTORE_ALL = 8'h12;
	localparam logic [7:0] CMD_VOUT_MODE   = 8'h20;
	localparam logic [7:0] CMD_VOUT_SET    = 8'h21;
	localparam logic [7:0] CMD_VIN_ON      = 8'h35;
	localparam logic [7:0] CMD_VOUT_OV_FLT = 8'h40;
	localparam logic [7:0] CMD_VOUT_OV_WRN = 8'h42;
	localparam logic [7:0] CMD_IOUT_OC_FLT = 8'h46;
	localparam logic [7:0] CMD_IOUT_OC_WRN = 8'h4a;
	localparam logic [7:0] CMD_OT_FLT      = 8'h4f;
	localparam logic [7:0] CMD_OT_WRN      = 8'h51;
	localparam logic [7:0] CMD_TON_DELAY   = 8'h60;
	localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
	localparam logic [7:0] CMD_FREQ_SWITCH = 8'h95;

	// Linear mode, exponent -12
	localparam logic [7:0] VOUT_MODE_VAL = 8'h14;
	localparam logic [4:0] EXP_VIN       = 5'h1d;
	localparam logic [4:0] EXP_IOUT      = 5'h1d;
	localparam logic [4:0] EXP_TEMP      = 5'h1e;
	localparam logic [4:0] EXP_FREQ      = 5'h01;
	localparam logic [4:0] EXP_TIME      = 5'h1f;

	typedef enum logic [2:0] {
		FMT_NONE, FMT_SEND, FMT_RO_BYTE, FMT_BYTE, FMT_VOUT, FMT_LIN
	} pmt_fmt_t;

	function automatic pmt_fmt_t pmt_cmd_fmt(input logic [7:0] cmd);
		case (cmd)
			CMD_CLEAR_FLT, CMD_STORE_ALL, CMD_RESTORE_ALL: return FMT_SEND;
			CMD_STATUS_BYTE, CMD_VOUT_MODE:                return FMT_RO_BYTE;
			CMD_OPERATION, CMD_ON_OFF_CFG, CMD_WRITE_PROT: return FMT_BYTE;
			CMD_VOUT_SET, CMD_VOUT_OV_FLT, CMD_VOUT_OV_WRN: return FMT_VOUT;
			CMD_VIN_ON, CMD_IOUT_OC_FLT, CMD_IOUT_OC_WRN,
			CMD_OT_FLT, CMD_OT_WRN, CMD_TON_DELAY,
			CMD_FREQ_SWITCH:                               return FMT_LIN;
			default:                                       return FMT_NONE;
		endcase
	endfunction

	function automatic logic [4:0] pmt_cmd_exp(input logic [7:0] cmd);
		case (cmd)
			CMD_VIN_ON:                         return EXP_VIN;
			CMD_IOUT_OC_FLT, CMD_IOUT_OC_WRN:   return EXP_IOUT;
			CMD_OT_FLT, CMD_OT_WRN:             return EXP_TEMP;
			CMD_FREQ_SWITCH:                    return EXP_FREQ;
			default:                            return EXP_TIME;
		endcase
	endfunction

	function automatic logic [7:0] pmt_crc8(input logic [7:0] crc,
	                                        input logic [7:0] data);
		logic [7:0] c;
		c = crc ^ data;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
		end
		return c;
	endfunction

endpackage

// ---- pmt_ram_if.sv ----
// Purpose: Port bundle between the protocol engine and working memory
// Assumes: One write and one registered read per cycle
// Notes:   Read data lags the read address by one cycle
`timescale 1ns/1ps
interface pmt_ram_if #(parameter int AW = 8, parameter int DW = 16);
	logic          we;
	logic [AW-1:0] waddr;
	logic [DW-1:0] wdata;
	logic [AW-1:0] raddr;
	logic [DW-1:0] rdata;
	modport ctrl (output we, output waddr, output wdata, output raddr,
	              input rdata);
	modport mem (input we, input waddr, input wdata, input raddr,
	             output rdata);
endinterface

// ---- pmt_target.sv ----
// Purpose: Target side of the power module management serial port
// Assumes: Bus clock and data sampled by clk_i, so bus rate <= 400 kHz
// Notes:   Host writes always carry a check byte except bare send byte
//
// Behaviour
// - Works at both standard and fast bus rates
// - Data, clock, alert lines plus address select
// - Check the host's appended check byte
// - Append a check byte to every response
// - Alert pulls shared line low, else released
// - Keep answering own address while alerting
// - Clear faults command clears flags, releases alert
// - Settings persist only on store-default command
// - Fourteen select bands map to addresses 96..109
// - Out of band selection falls back to 126
// - Also acknowledge reserved factory address 127
// - Linear data, per-command fixed exponent only
// - No direct numeric format anywhere
// - Output voltage words: unsigned, exponent minus twelve
// - Other values: 5-bit exponent, 11-bit mantissa
// - Fixed exponents per quantity as listed
`timescale 1ns/1ps
module pmt_target #(
	parameter int SEL_W = 4
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic             scl_i,
	input  wire logic             sda_i,
	input  wire logic [SEL_W-1:0] address_select_pin_i,
	input  wire logic [7:0]       fault_i,
	output logic                  sda_o,
	output logic                  sda_oe_n_o,
	output logic                  alert_o,
	output logic                  alert_oe_n_o,
	output logic                  store_default_o,
	output logic                  restore_default_o,
	output logic [6:0]            bus_address_o
);
	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_RX, ST_ACK, ST_TX, ST_MACK, ST_SKIP
	} pmt_state_t;

	pmt_ram_if #(.AW(8), .DW(16)) ram ();

	pmt_cfg_ram #(.AW(8), .DW(16)) u_ram (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.ram     (ram)
	);

	logic             scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
	logic [7:0]       flt_m, flt_s;
	logic [SEL_W-1:0] sel_m, sel_s;
	logic             scl_rise, scl_fall, start_c, stop_c;

	// Both bus lines see the same two-stage delay so start/stop stay valid
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			{scl_m, scl_s, scl_d} <= 3'h7;
			{sda_m, sda_s, sda_d} <= 3'h7;
			flt_m <= 8'h00;
			flt_s <= 8'h00;
			sel_m <= '0;
			sel_s <= '0;
		end else begin
			{scl_m, scl_s, scl_d} <= {scl_i, scl_m, scl_s};
			{sda_m, sda_s, sda_d} <= {sda_i, sda_m, sda_s};
			flt_m <= fault_i;
			flt_s <= flt_m;
			sel_m <= address_select_pin_i;
			sel_s <= sel_m;
		end
	end

	// Edge timing only relies on 100 or 400 kHz being far below clk_i
	assign scl_rise = scl_s & ~scl_d;
	assign scl_fall = ~scl_s & scl_d;
	assign start_c  = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_c   = scl_s & scl_d & ~sda_d & sda_s;

	logic [1:0] sel_wait;
	logic       addr_done;

	// Select level caught once, after the synchroniser has settled
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sel_wait      <= 2'h0;
			addr_done     <= 1'b0;
			bus_address_o <= pmt_pkg::ADDR_FALLBACK;
		end else if (!addr_done) begin
			if (sel_wait == pmt_pkg::SEL_SETTLE) begin
				addr_done <= 1'b1;
				if (32'(sel_s) < pmt_pkg::ADDR_BANDS) begin
					bus_address_o <= pmt_pkg::ADDR_BASE + 7'(sel_s);
				end else begin
					bus_address_o <= pmt_pkg::ADDR_FALLBACK;
				end
			end else begin
				sel_wait <= sel_wait + 2'h1;
			end
		end
	end

	pmt_state_t       state;
	logic [3:0]       bit_cnt;
	logic [7:0]       shreg, tx_byte, crc, cmd, d0, d1;
	logic [2:0]       n_rx;
	logic [1:0]       tx_idx;
	logic             rw, drive, commit;
	logic [7:0]       status;
	pmt_pkg::pmt_fmt_t fmt;
	logic             addr_hit, byte_rsp;
	logic [7:0]       byte_val;

	assign fmt      = pmt_pkg::pmt_cmd_fmt(cmd);
	assign byte_rsp = (fmt == pmt_pkg::FMT_RO_BYTE) ||
	                  (fmt == pmt_pkg::FMT_BYTE);
	assign byte_val = (cmd == pmt_pkg::CMD_STATUS_BYTE) ? status :
	                  (cmd == pmt_pkg::CMD_VOUT_MODE) ?
	                  pmt_pkg::VOUT_MODE_VAL : ram.rdata[7:0];
	// Alert state plays no part in matching
	assign addr_hit = (shreg[7:1] == pmt_pkg::ADDR_FACTORY) ||
	                  (addr_done && shreg[7:1] == bus_address_o);
	assign ram.raddr = cmd;

	// Reply byte by position: data bytes, then check byte, then idle
	function automatic logic [7:0] tx_pick(input logic [1:0] idx,
	                                       input logic       one,
	                                       input logic [7:0] bval,
	                                       input logic [15:0] word,
	                                       input logic [7:0] pec);
		if (one) begin
			return (idx == 2'h0) ? bval :
			       (idx == 2'h1) ? pec : pmt_pkg::IDLE_BYTE;
		end
		return (idx == 2'h0) ? word[7:0] :
		       (idx == 2'h1) ? word[15:8] :
		       (idx == 2'h2) ? pec : pmt_pkg::IDLE_BYTE;
	endfunction

	logic [7:0] tx_next;
	assign tx_next = tx_pick(tx_idx, byte_rsp, byte_val, ram.rdata, crc);

	// Byte engine: the only writer of the data line enable
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state   <= ST_IDLE;
			bit_cnt <= 4'h0;
			shreg   <= 8'h00;
			tx_byte <= 8'h00;
			crc     <= pmt_pkg::CRC_INIT;
			cmd     <= 8'h00;
			d0      <= 8'h00;
			d1      <= 8'h00;
			n_rx    <= 3'h0;
			tx_idx  <= 2'h0;
			rw      <= 1'b0;
			drive   <= 1'b0;
			commit  <= 1'b0;
		end else begin
			commit <= 1'b0;
			if (start_c) begin
				state   <= ST_ADDR;
				bit_cnt <= 4'h0;
				drive   <= 1'b0;
				// Every reply restarts at its first byte, else a stale
				// position from the last read would pick idle or check
				tx_idx  <= 2'h0;
				if (state == ST_IDLE || state == ST_SKIP) begin
					crc  <= pmt_pkg::CRC_INIT;
					n_rx <= 3'h0;
				end
			end else if (stop_c) begin
				commit <= (state == ST_RX) && !rw && (n_rx != 3'h0);
				state  <= ST_IDLE;
				drive  <= 1'b0;
			end else if (scl_rise) begin
				case (state)
					ST_ADDR, ST_RX: begin
						shreg   <= {shreg[6:0], sda_s};
						bit_cnt <= bit_cnt + 4'h1;
					end
					ST_TX: bit_cnt <= bit_cnt + 4'h1;
					ST_MACK: begin
						if (sda_s) begin
							state <= ST_SKIP;
						end
					end
					default: ;
				endcase
			end else if (scl_fall) begin
				case (state)
					ST_ADDR: begin
						if (bit_cnt == pmt_pkg::BITS_PER_BYTE) begin
							crc <= pmt_pkg::pmt_crc8(crc, shreg);
							if (addr_hit) begin
								rw    <= shreg[0];
								drive <= 1'b1;
								state <= ST_ACK;
							end else begin
								state <= ST_SKIP;
							end
						end
					end
					ST_RX: begin
						if (bit_cnt == pmt_pkg::BITS_PER_BYTE) begin
							crc <= pmt_pkg::pmt_crc8(crc, shreg);
							case (n_rx)
								3'h0:    cmd <= shreg;
								3'h1:    d0 <= shreg;
								3'h2:    d1 <= shreg;
								default: ;
							endcase
							if (n_rx != 3'h7) begin
								n_rx <= n_rx + 3'h1;
							end
							drive <= 1'b1;
							state <= ST_ACK;
						end
					end
					ST_ACK, ST_MACK: begin
						bit_cnt <= 4'h0;
						if (rw) begin
							// Reply bytes also enter the running check
							crc     <= pmt_pkg::pmt_crc8(crc, tx_next);
							tx_byte <= tx_next;
							tx_idx  <= (state == ST_ACK) ? 2'h1 :
							           (tx_idx == 2'h3) ? 2'h3 :
							           tx_idx + 2'h1;
							drive   <= ~tx_next[7];
							state   <= ST_TX;
						end else begin
							drive <= 1'b0;
							state <= ST_RX;
						end
					end
					ST_TX: begin
						if (bit_cnt == pmt_pkg::BITS_PER_BYTE) begin
							drive <= 1'b0;
							state <= ST_MACK;
						end else begin
							drive   <= ~tx_byte[6];
							tx_byte <= {tx_byte[6:0], 1'b0};
						end
					end
					default: ;
				endcase
			end
		end
	end

	logic pec_ok, exp_ok, act_clear, act_store, act_restore, act_wr;
	logic act_bad;
	assign pec_ok = (crc == 8'h00);
	assign exp_ok = (d1[7:3] == pmt_pkg::pmt_cmd_exp(cmd));

	always_comb begin
		act_clear   = 1'b0;
		act_store   = 1'b0;
		act_restore = 1'b0;
		act_wr      = 1'b0;
		act_bad     = 1'b0;
		case (fmt)
			pmt_pkg::FMT_SEND: begin
				if (n_rx == 3'h1 || (n_rx == 3'h2 && pec_ok)) begin
					act_clear   = (cmd == pmt_pkg::CMD_CLEAR_FLT);
					act_store   = (cmd == pmt_pkg::CMD_STORE_ALL);
					act_restore = (cmd == pmt_pkg::CMD_RESTORE_ALL);
				end else begin
					act_bad = 1'b1;
				end
			end
			pmt_pkg::FMT_BYTE: begin
				act_wr  = (n_rx == 3'h3) && pec_ok;
				act_bad = (n_rx != 3'h1) && !act_wr;
			end
			pmt_pkg::FMT_VOUT: begin
				act_wr  = (n_rx == 3'h4) && pec_ok;
				act_bad = (n_rx != 3'h1) && !act_wr;
			end
			pmt_pkg::FMT_LIN: begin
				// Foreign exponent rejected rather than rescaled
				act_wr  = (n_rx == 3'h4) && pec_ok && exp_ok;
				act_bad = (n_rx != 3'h1) && !act_wr;
			end
			// Read-only and unknown codes, incl. mode writes
			default: act_bad = (n_rx != 3'h1);
		endcase
	end

	logic clear_p, cml_p;

	// Writes land in working memory only; flash copy is a pulse out
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ram.we            <= 1'b0;
			ram.waddr         <= 8'h00;
			ram.wdata         <= 16'h0000;
			clear_p           <= 1'b0;
			cml_p             <= 1'b0;
			store_default_o   <= 1'b0;
			restore_default_o <= 1'b0;
		end else begin
			ram.we            <= commit && act_wr;
			ram.waddr         <= cmd;
			ram.wdata         <= (fmt == pmt_pkg::FMT_BYTE) ?
			                     {8'h00, d0} : {d1, d0};
			clear_p           <= commit && act_clear;
			cml_p             <= commit && act_bad;
			store_default_o   <= commit && act_store;
			restore_default_o <= commit && act_restore;
		end
	end

	// New events win over a clear in the same cycle
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			status <= 8'h00;
		end else begin
			status <= (clear_p ? 8'h00 : status) | flt_s |
			          (8'(cml_p) << pmt_pkg::STAT_CML_BIT);
		end
	end

	// Open drain: both lines only ever pulled low
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sda_o        <= 1'b0;
			sda_oe_n_o   <= 1'b1;
			alert_o      <= 1'b0;
			alert_oe_n_o <= 1'b1;
		end else begin
			sda_o        <= 1'b0;
			sda_oe_n_o   <= ~drive;
			alert_o      <= 1'b0;
			alert_oe_n_o <= ~(|status);
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	a_alert_follow: assert property ((|status) |=> !alert_oe_n_o)
		else $error("alert not driven while flags set");
	a_clear_release: assert property (
		clear_p && flt_s == 8'h00 && !cml_p |=> status == 8'h00 ##1 alert_oe_n_o)
		else $error("clear faults did not release alert");
	a_addr_band: assert property (
		$rose(addr_done) && 32'($past(sel_s)) < pmt_pkg::ADDR_BANDS
		|-> bus_address_o == pmt_pkg::ADDR_BASE + 7'($past(sel_s)))
		else $error("band address wrong");
	a_addr_fallback: assert property (
		$rose(addr_done) && 32'($past(sel_s)) >= pmt_pkg::ADDR_BANDS
		|-> bus_address_o == pmt_pkg::ADDR_FALLBACK)
		else $error("fallback address wrong");
	a_factory_ack: assert property (
		state == ST_ADDR && scl_fall && bit_cnt == 4'h8 &&
		shreg[7:1] == pmt_pkg::ADDR_FACTORY && !start_c && !stop_c
		|=> ##1 !sda_oe_n_o)
		else $error("factory address not acknowledged");
	a_pec_reject: assert property (
		commit && !pec_ok && n_rx > 3'h1 |=> !ram.we ##1 status[1])
		else $error("bad check byte not discarded");
	a_store_only: assert property (
		store_default_o |-> $past(commit) && $past(cmd) == pmt_pkg::CMD_STORE_ALL)
		else $error("store pulse without command");
	a_exp_fixed: assert property (
		ram.we && pmt_pkg::pmt_cmd_fmt(ram.waddr) == pmt_pkg::FMT_LIN
		|-> ram.wdata[15:11] == pmt_pkg::pmt_cmd_exp(ram.waddr))
		else $error("foreign exponent accepted");
	a_pec_out: assert property (
		state == ST_MACK && scl_fall && rw && !byte_rsp && tx_idx == 2'h2 &&
		!start_c && !stop_c |=> tx_byte == $past(crc))
		else $error("reply check byte wrong");
	a_mode_reply: assert property (
		state == ST_ACK && scl_fall && rw && cmd == pmt_pkg::CMD_VOUT_MODE &&
		!start_c && !stop_c |=> tx_byte == pmt_pkg::VOUT_MODE_VAL)
		else $error("mode byte wrong");

	c_word_write: cover property (ram.we);
	c_read_reply: cover property (state == ST_TX && rw);
	c_clear: cover property (clear_p ##2 alert_oe_n_o);
	c_bad_pec: cover property (cml_p);
endmodule

// ---- pmt_target_bench.sv ----
// Purpose: Self-checking bench for the management port target
// Assumes: Host model on the bus, pull-ups modelled by wired-AND
// Notes:   Select code is a band number; 14 and up are out of range
`timescale 1ns/1ps
module pmt_target_bench;
	logic       clk_i = 1'b0;
	logic       rst_n_i = 1'b0;
	logic [3:0] sel = 4'h0;
	logic [7:0] fault = 8'h00;
	logic       scl, sda_w, h_oe_n, t_sda, t_oe_n;
	logic       alert, alert_oe_n, alert_w, store_p, rest_p;
	logic [6:0] addr;
	logic [15:0] d;
	logic       k;
	int         err_total = 0;
	int         checked = 0;
	int         n_store = 0;
	int         n_rest = 0;

	always #12.5 clk_i = ~clk_i;
	assign sda_w = h_oe_n & (t_oe_n | t_sda);
	assign alert_w = alert_oe_n | alert;

	pmt_target #(.SEL_W(4)) i_pmt_target (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda_w),
		.address_select_pin_i(sel), .fault_i(fault), .sda_o(t_sda),
		.sda_oe_n_o(t_oe_n), .alert_o(alert), .alert_oe_n_o(alert_oe_n),
		.store_default_o(store_p), .restore_default_o(rest_p),
		.bus_address_o(addr));
	pmt_host_model i_pmt_host_model (
		.sda_i(sda_w), .scl_o(scl), .sda_oe_n_o(h_oe_n));

	// Counts high cycles, so a one-cycle pulse adds exactly one
	always @(posedge clk_i) begin
		if (store_p === 1'b1) n_store++;
		if (rest_p === 1'b1) n_rest++;
	end

	task automatic results();
		$display("checked=%0d err_total=%0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmp_bit(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic do_reset(input logic [3:0] code);
		@(negedge clk_i);
		rst_n_i = 1'b0;
		sel = code;
		repeat (8) @(negedge clk_i);
		rst_n_i = 1'b1;
		repeat (12) @(negedge clk_i);
	endtask

	// Write frame: n data bytes, low first, then check byte
	task automatic wr(input logic [6:0] a, input logic [7:0] cmd,
	                  input int n, input logic [15:0] dat,
	                  input logic bad, output logic ack);
		logic x;
		i_pmt_host_model.start(1'b0);
		i_pmt_host_model.put_byte({a, 1'b0}, ack);
		if (ack) begin
			i_pmt_host_model.put_byte(cmd, x);
			for (int i = 0; i < n; i++)
				i_pmt_host_model.put_byte(dat[8*i +: 8], x);
			i_pmt_host_model.put_byte(i_pmt_host_model.pec ^ {7'h00, bad},
			                          x);
		end
		i_pmt_host_model.stop();
	endtask

	task automatic rd(input logic [6:0] a, input logic [7:0] cmd,
	                  input int n, output logic [15:0] dat);
		logic       x;
		logic [7:0] b;
		logic [7:0] exp_pec;
		dat = 16'h0000;
		i_pmt_host_model.start(1'b0);
		i_pmt_host_model.put_byte({a, 1'b0}, x);
		i_pmt_host_model.put_byte(cmd, x);
		i_pmt_host_model.start(1'b1);
		i_pmt_host_model.put_byte({a, 1'b1}, x);
		for (int i = 0; i < n; i++) begin
			i_pmt_host_model.get_byte(1'b0, b);
			dat[8*i +: 8] = b;
		end
		exp_pec = i_pmt_host_model.pec;
		i_pmt_host_model.get_byte(1'b1, b);
		i_pmt_host_model.stop();
		cmp({8'h00, b}, {8'h00, exp_pec});
	endtask

	task automatic t_addr();
		logic [3:0] codes [5] = '{4'h0, 4'h5, 4'hd, 4'he, 4'hf};
		logic [6:0] a;
		foreach (codes[i]) begin
			do_reset(codes[i]);
			a = (codes[i] < 4'he) ? 7'h60 + {3'h0, codes[i]} : 7'h7e;
			cmp({9'h000, addr}, {9'h000, a});
			cmp_bit(alert_w, 1'b1);
			wr(a, 8'h03, 0, 16'h0000, 1'b0, k);
			cmp_bit(k, 1'b1);
			wr(a - 7'h01, 8'h03, 0, 16'h0000, 1'b0, k);
			cmp_bit(k, 1'b0);
			// Factory address only probed, never used for settings
			wr(7'h7f, 8'h03, 0, 16'h0000, 1'b0, k);
			cmp_bit(k, 1'b1);
		end
	endtask

	task automatic t_vout();
		wr(7'h62, 8'h21, 2, 16'hc000, 1'b0, k);
		i_pmt_host_model.half = 5000;
		rd(7'h62, 8'h21, 2, d);
		i_pmt_host_model.half = 100;
		cmp(d, 16'hc000);
		rd(7'h62, 8'h20, 1, d);
		cmp(d, 16'h0014);
		wr(7'h62, 8'h01, 1, 16'h0080, 1'b0, k);
		rd(7'h62, 8'h01, 1, d);
		cmp(d, 16'h0080);
		// Switching the mode byte to another format must be refused
		wr(7'h62, 8'h20, 1, 16'h0040, 1'b0, k);
		rd(7'h62, 8'h20, 1, d);
		cmp(d, 16'h0014);
		cmp_bit(alert_w, 1'b0);
		wr(7'h62, 8'h03, 0, 16'h0000, 1'b0, k);
		cmp_bit(alert_w, 1'b1);
	endtask

	task automatic t_lin();
		logic [7:0] cmds [7] = '{8'h35, 8'h46, 8'h4a, 8'h4f, 8'h51,
		                         8'h60, 8'h95};
		logic [4:0] exps [7] = '{5'h1d, 5'h1d, 5'h1d, 5'h1e, 5'h1e,
		                         5'h1f, 5'h01};
		foreach (cmds[i]) begin
			wr(7'h62, cmds[i], 2, {exps[i], 11'h110}, 1'b0, k);
			rd(7'h62, cmds[i], 2, d);
			cmp(d, {exps[i], 11'h110});
		end
		cmp_bit(alert_w, 1'b1);
	endtask

	task automatic t_reject();
		wr(7'h62, 8'h35, 2, 16'hf110, 1'b0, k);
		rd(7'h62, 8'h35, 2, d);
		cmp(d, 16'he910);
		cmp_bit(alert_w, 1'b0);
		// Alerting target must still answer its own address
		rd(7'h62, 8'h78, 1, d);
		cmp(d, 16'h0002);
		wr(7'h62, 8'h03, 0, 16'h0000, 1'b0, k);
		cmp_bit(alert_w, 1'b1);
		wr(7'h62, 8'h21, 2, 16'h1234, 1'b1, k);
		rd(7'h62, 8'h21, 2, d);
		cmp(d, 16'hc000);
		cmp_bit(alert_w, 1'b0);
		wr(7'h62, 8'h03, 0, 16'h0000, 1'b0, k);
		rd(7'h62, 8'h78, 1, d);
		cmp(d, 16'h0000);
	endtask

	task automatic t_fault();
		@(negedge clk_i);
		fault = 8'h08;
		repeat (10) @(negedge clk_i);
		fault = 8'h00;
		repeat (10) @(negedge clk_i);
		cmp_bit(alert_w, 1'b0);
		rd(7'h62, 8'h78, 1, d);
		cmp(d, 16'h0008);
		wr(7'h62, 8'h03, 0, 16'h0000, 1'b0, k);
		cmp_bit(alert_w, 1'b1);
	endtask

	task automatic t_store();
		cmp(n_store[15:0], 16'h0000);
		wr(7'h62, 8'h11, 0, 16'h0000, 1'b0, k);
		cmp(n_store[15:0], 16'h0001);
		wr(7'h62, 8'h12, 0, 16'h0000, 1'b0, k);
		cmp(n_rest[15:0], 16'h0001);
	endtask

	initial begin
		t_addr();
		do_reset(4'h2);
		t_vout();
		t_lin();
		t_reject();
		t_fault();
		t_store();
		results();
	end

	// Whole run is about 1 ms, over half of it the one 100 kHz read; 2 ms means a hang
	initial begin
		#2000000;
		err_total++;
		results();
	end
endmodule
